// ===== core/pcs_consts.svh
// Purpose: Shared constants of the program counter sequencer.
// Assumes: Included by bare name; definitions only.
// Notes: Offsets are byte addresses on the register bus.
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// ****************************************
// Widths and vectors
// ****************************************
`define PCS_PC_W 21
`define PCS_SP_W 5
`define PCS_STACK_DEPTH 31
`define PCS_RESET_VEC 21'h000000
`define PCS_VEC_HIGH 21'h000008
`define PCS_VEC_LOW 21'h000018
`define PCS_STEP 21'h000002
`define PCS_MEM_SMALL 21'h00C000
`define PCS_MEM_LARGE 21'h010000

// ****************************************
// Register offsets and fields
// ****************************************
`define PCS_OFS_LOW 8'h00
`define PCS_OFS_HLAT 8'h04
`define PCS_OFS_ULAT 8'h08
`define PCS_OFS_CTRL 8'h0C
`define PCS_OFS_STK 8'h10
`define PCS_OFS_TOS 8'h14
`define PCS_CTRL_RUN 0
`define PCS_CTRL_GEL 1
`define PCS_CTRL_GEH 2
`define PCS_STK_FULL 7
`define PCS_CTRL_RST 3'h0
`define PCS_RESP_OK 2'h0
`define PCS_RESP_ERR 2'h2

`endif

// ===== core/pcs_pkg.sv
// Purpose: Types of the program counter sequencer.
// Assumes: Used by scoped names only.
// Notes: Constants live in pcs_consts.svh.
package pcs_pkg;
  // Source that updates the counter in a cycle; after PCS_SRC_NONE, highest first
  typedef enum logic [2:0] {
    PCS_SRC_NONE,
    PCS_SRC_WAKE,
    PCS_SRC_LOAD,
    PCS_SRC_LOWWR,
    PCS_SRC_STEP
  } pcs_src_t;
endpackage

// ===== core/pcs_stack_ram.sv
// Purpose: Return stack storage with registered read data.
// Assumes: One write and one read port on one clock.
// Notes: Location zero exists but is never written by the sequencer.
`timescale 1ns/1ps
`default_nettype none
module pcs_stack_ram #(
  parameter int AW = 5,
  parameter int DW = 21
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Storage write
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read, one cycle after the address
  always_ff @(posedge clk) begin
    rdata_q <= mem[raddr];
  end
endmodule
`default_nettype wire

// ===== core/pcs_sequencer.sv
// Purpose: Program counter, latches, vectors and return stack push.
// Assumes: Core control strobes come from logic on clk.
// Notes: Registers reached over AXI4-Lite, one access of each kind.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"
module pcs_sequencer #(
  parameter bit LARGE_MEM = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  // Core control
  input wire logic step_en,
  input wire logic load_en,
  input wire logic load_push,
  input wire logic [20:0] load_target,
  input wire logic wake_irq,
  input wire logic wake_high,
  // Instruction fetch bus
  output logic [20:0] fetch_addr,
  input wire logic [15:0] fetch_rdata,
  output logic [15:0] fetch_instr_q,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [20:0] MEM_TOP = LARGE_MEM ? `PCS_MEM_LARGE : `PCS_MEM_SMALL;
  localparam logic [4:0] SP_MAX = 5'(`PCS_STACK_DEPTH);

  // ****************************************
  // Helper functions
  // ****************************************
  // Clear bit zero
  function automatic logic [20:0] align(input logic [20:0] v);
    align = {v[20:1], 1'b0};
  endfunction

  // Known register offset
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `PCS_OFS_LOW) || (a == `PCS_OFS_HLAT) || (a == `PCS_OFS_ULAT) ||
             (a == `PCS_OFS_CTRL) || (a == `PCS_OFS_STK) || (a == `PCS_OFS_TOS);
  endfunction

  // ****************************************
  // State
  // ****************************************
  // 21-bit byte counter
  logic [20:0] pc_q, pc_d;
  logic [7:0] high_byte_latch_q;
  logic [4:0] upper_byte_latch_q;
  logic [2:0] ctrl_q;
  logic [4:0] sp_q, sp_d;
  logic full_q;
  logic [20:0] tos_q;
  pcs_pkg::pcs_src_t src;
  logic [7:0] aw_addr_q;
  logic aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire, rd_fire;
  logic low_wr, low_rd, hlat_wr, ulat_wr, ctrl_wr, stk_wr;
  logic wake_vec, push, push_ok;
  logic [20:0] push_val;
  logic [20:0] wake_target;

  // ****************************************
  // Register bus: write path
  // ****************************************
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  // Write completes once address and data are both held and no response is pending
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

  // Capture address and data in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  // Response held until the master takes it
  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= `PCS_RESP_OK;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(aw_addr_q) ? `PCS_RESP_OK : `PCS_RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Only byte lane 0 carries register data
  assign low_wr = wr_fire && w_strb_q[0] && (aw_addr_q == `PCS_OFS_LOW);
  assign hlat_wr = wr_fire && w_strb_q[0] && (aw_addr_q == `PCS_OFS_HLAT);
  assign ulat_wr = wr_fire && w_strb_q[0] && (aw_addr_q == `PCS_OFS_ULAT);
  assign ctrl_wr = wr_fire && w_strb_q[0] && (aw_addr_q == `PCS_OFS_CTRL);
  assign stk_wr = wr_fire && w_strb_q[0] && (aw_addr_q == `PCS_OFS_STK);

  // ****************************************
  // Register bus: read path
  // ****************************************
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign low_rd = rd_fire && (s_axi_araddr == `PCS_OFS_LOW);

  // Read data one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rresp_q <= `PCS_RESP_OK;
      rdata_q <= 32'h00000000;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= mapped(s_axi_araddr) ? `PCS_RESP_OK : `PCS_RESP_ERR;
      case (s_axi_araddr)
        `PCS_OFS_LOW: begin
          rdata_q <= {24'h000000, pc_q[7:0]};
        end
        `PCS_OFS_HLAT: begin
          rdata_q <= {24'h000000, high_byte_latch_q};
        end
        `PCS_OFS_ULAT: begin
          rdata_q <= {27'h0000000, upper_byte_latch_q};
        end
        `PCS_OFS_CTRL: begin
          rdata_q <= {29'h00000000, ctrl_q};
        end
        `PCS_OFS_STK: begin
          rdata_q <= {24'h000000, full_q, 2'h0, sp_q};
        end
        `PCS_OFS_TOS: begin
          rdata_q <= {11'h000, tos_q};
        end
        default: begin
          rdata_q <= 32'h00000000;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Control register and latches
  // ****************************************
  // Control: run, low and high priority global enables
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `PCS_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= w_data_q[2:0];
    end
  end

  // Latches: a low byte read refreshes them, a direct write wins
  always_ff @(posedge clk) begin
    if (rst) begin
      high_byte_latch_q <= 8'h00;
      upper_byte_latch_q <= 5'h00;
    end else begin
      if (low_rd) begin
        high_byte_latch_q <= pc_q[15:8];
        upper_byte_latch_q <= pc_q[20:16];
      end
      if (hlat_wr) begin
        high_byte_latch_q <= w_data_q[7:0];
      end
      if (ulat_wr) begin
        upper_byte_latch_q <= w_data_q[4:0];
      end
    end
  end

  // ****************************************
  // Counter update
  // ****************************************
  // Vector on enabled wake
  assign wake_vec = wake_irq && (ctrl_q[`PCS_CTRL_GEL] || ctrl_q[`PCS_CTRL_GEH]);
  assign wake_target = wake_high ? `PCS_VEC_HIGH : `PCS_VEC_LOW;

  // Pick the one source that moves the counter this cycle
  always_comb begin
    if (wake_vec) begin
      src = pcs_pkg::PCS_SRC_WAKE;
    end else if (load_en) begin
      src = pcs_pkg::PCS_SRC_LOAD;
    end else if (low_wr) begin
      src = pcs_pkg::PCS_SRC_LOWWR;
    end else if (step_en && ctrl_q[`PCS_CTRL_RUN]) begin
      src = pcs_pkg::PCS_SRC_STEP;
    end else begin
      src = pcs_pkg::PCS_SRC_NONE;
    end
  end

  always_comb begin
    case (src)
      pcs_pkg::PCS_SRC_WAKE: begin
        pc_d = wake_target;
      end
      pcs_pkg::PCS_SRC_LOAD: begin
        pc_d = align(load_target);
      end
      pcs_pkg::PCS_SRC_LOWWR: begin
        pc_d = align({upper_byte_latch_q, high_byte_latch_q, w_data_q[7:0]});
      end
      pcs_pkg::PCS_SRC_STEP: begin
        pc_d = align(pc_q + `PCS_STEP);
      end
      default: begin
        pc_d = pc_q;
      end
    endcase
  end

  // Reset to vector zero; width, bit zero
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q <= `PCS_RESET_VEC;
    end else begin
      pc_q <= align(pc_d);
    end
  end

  // ****************************************
  // Return stack push
  // ****************************************
  // Wake or call pushes
  assign push = wake_vec || (load_en && load_push);
  // Interrupt saves the current counter, a call the next word
  assign push_val = wake_vec ? pc_q : align(pc_q + `PCS_STEP);
  assign push_ok = push && (sp_q != SP_MAX);

  // Increment then write at new pointer
  always_comb begin
    sp_d = sp_q;
    if (push_ok) begin
      sp_d = sp_q + 5'h01;
    end else if (stk_wr) begin
      sp_d = w_data_q[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sp_q <= 5'h00;
    end else begin
      sp_q <= sp_d;
    end
  end

  // Full flag: set by the 31st push, cleared by writing 1; set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      full_q <= 1'b0;
    end else if (push && (sp_d == SP_MAX)) begin
      full_q <= 1'b1;
    end else if (stk_wr && w_data_q[`PCS_STK_FULL]) begin
      full_q <= 1'b0;
    end
  end

  // Stack storage, top of stack lags the pointer by one cycle
  pcs_stack_ram #(
    .AW(`PCS_SP_W),
    .DW(`PCS_PC_W)
  ) u_stack (
    .clk(clk),
    .we(push_ok),
    .waddr(sp_d),
    .wdata(push_val),
    .raddr(sp_q),
    .rdata_q(tos_q)
  );

  // ****************************************
  // Instruction fetch bus
  // ****************************************
  // Own bus, no arbitration with registers
  assign fetch_addr = pc_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_instr_q <= 16'h0000;
    end else if (pc_q >= MEM_TOP) begin
      fetch_instr_q <= 16'h0000;
    end else begin
      fetch_instr_q <= fetch_rdata;
    end
  end
endmodule
`default_nettype wire

// ===== verification/pcs_seq_monitor.sv
// Purpose: Port assertions for the sequencer.
// Assumes: Bound to pcs_sequencer; sync active-high reset.
// Notes: Sees only top-level ports.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"
module pcs_seq_monitor #(
  parameter bit LARGE_MEM = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load_en,
  input wire logic [20:0] load_target,
  input wire logic wake_irq,
  input wire logic wake_high,
  input wire logic [20:0] fetch_addr,
  input wire logic [15:0] fetch_rdata,
  input wire logic [15:0] fetch_instr_q,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid
);
  // Memory top for this build
  logic [20:0] top;
  assign top = LARGE_MEM ? `PCS_MEM_LARGE : `PCS_MEM_SMALL;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_bit_zero: assert property (fetch_addr[0] == 1'b0)
    else $error("counter bit zero set");
  a_reset_vector: assert property (disable iff (1'b0) rst |=> fetch_addr == `PCS_RESET_VEC)
    else $error("counter not at reset vector");
  // A low-byte write shows as a rising write response
  a_step_two: assert property (!load_en && !wake_irq |=> $rose(s_axi_bvalid)
    || fetch_addr == $past(fetch_addr) || fetch_addr == $past(fetch_addr) + `PCS_STEP)
    else $error("counter moved other than by two");
  a_load_target: assert property (load_en && !wake_irq |=>
    fetch_addr == {$past(load_target[20:1]), 1'b0})
    else $error("load target not taken");
  a_wake_vector: assert property (wake_irq && !load_en |=> $rose(s_axi_bvalid)
    || fetch_addr == $past(fetch_addr) || fetch_addr == $past(fetch_addr) + `PCS_STEP
    || fetch_addr == ($past(wake_high) ? `PCS_VEC_HIGH : `PCS_VEC_LOW))
    else $error("wake vector wrong");
  a_fetch_zero: assert property (fetch_addr >= top |=> fetch_instr_q == 16'h0000)
    else $error("fetch above memory not zero");
  a_fetch_data: assert property (fetch_addr < top |=> fetch_instr_q == $past(fetch_rdata))
    else $error("fetched word wrong");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind pcs_sequencer pcs_seq_monitor #(.LARGE_MEM(LARGE_MEM)) mon_u (.clk(clk), .rst(rst),
  .load_en(load_en), .load_target(load_target), .wake_irq(wake_irq), .wake_high(wake_high),
  .fetch_addr(fetch_addr), .fetch_rdata(fetch_rdata), .fetch_instr_q(fetch_instr_q),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// ===== verification/pcs_prog_mem.sv
// Purpose: Program memory model on the fetch bus.
// Assumes: Combinational read, one word per address.
// Notes: Answers above the top too, so zeroing is the design's job.
`timescale 1ns/1ps
`default_nettype none
module pcs_prog_mem (
  input wire logic [20:0] fetch_addr,
  output logic [15:0] fetch_rdata
);
  // Word differs at every even address below 0x20000, so a stale fetch shows
  assign fetch_rdata = fetch_addr[16:1] ^ 16'hA5C3;
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the sequencer.
// Assumes: 200 MHz clock, sync active-high reset.
// Notes: Inputs change by NBA just after rising edges.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"
module testbench;
  logic clk, rst, step_en, load_en, load_push, wake_irq, wake_high;
  logic [20:0] load_target, fetch_addr;
  logic [15:0] fetch_rdata, fetch_instr_q;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0] bresp, rresp, rd_r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  pcs_sequencer #(.LARGE_MEM(1'b1)) dut_u (.clk(clk), .rst(rst), .step_en(step_en),
    .load_en(load_en), .load_push(load_push), .load_target(load_target), .wake_irq(wake_irq),
    .wake_high(wake_high), .fetch_addr(fetch_addr), .fetch_rdata(fetch_rdata),
    .fetch_instr_q(fetch_instr_q), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  pcs_prog_mem mem_u (.fetch_addr(fetch_addr), .fetch_rdata(fetch_rdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard, far above the hundred or so cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Offer address and data together, drop each once taken, then await response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (!tw && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    // Let an edge pass so a following call never reassigns in this step
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rd_v = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // One cycle of core control, then one idle edge
  task automatic core(input logic s, l, w, h, input logic [20:0] t);
    step_en <= s;
    load_en <= l;
    wake_irq <= w;
    wake_high <= h;
    load_target <= t;
    @(posedge clk);
    step_en <= 1'b0;
    load_en <= 1'b0;
    wake_irq <= 1'b0;
    @(posedge clk);
  endtask
  task automatic sc_reset();
    chk(32'(fetch_addr), 32'h0);
    rd(8'h10);
    chk(rd_v, 32'h0);
    rd(8'h20);
    chk(32'(rd_r), 32'(`PCS_RESP_ERR));
    chk(rd_v, 32'h0);
  endtask
  task automatic sc_latch();
    core(1'b0, 1'b1, 1'b0, 1'b0, 21'h12345);
    chk(32'(fetch_addr), 32'h12344);
    rd(8'h00);
    chk(rd_v, 32'h44);
    rd(8'h04);
    chk(rd_v, 32'h23);
    rd(8'h08);
    chk(rd_v, 32'h01);
    wr(8'h04, 32'h56);
    wr(8'h08, 32'h1F);
    chk(32'(fetch_addr), 32'h12344);
    wr(8'h00, 32'h9B);
    chk(32'(fetch_addr), 32'h1F569A);
    @(posedge clk);
    chk(32'(fetch_instr_q), 32'h0);
  endtask
  // Back-to-back steps with run on
  task automatic sc_step();
    core(1'b0, 1'b1, 1'b0, 1'b0, 21'h00100);
    wr(8'h0C, 32'h1);
    step_en <= 1'b1;
    repeat (3) @(posedge clk);
    step_en <= 1'b0;
    @(posedge clk);
    chk(32'(fetch_addr), 32'h106);
    @(posedge clk);
    chk(32'(fetch_instr_q), 32'(16'h0083 ^ 16'hA5C3));
    wr(8'h0C, 32'h0);
  endtask
  task automatic sc_wake();
    wr(8'h0C, 32'h4);
    core(1'b0, 1'b0, 1'b1, 1'b1, 21'h0);
    chk(32'(fetch_addr), 32'h8);
    rd(8'h10);
    chk(rd_v, 32'h1);
    rd(8'h14);
    chk(rd_v, 32'h106);
    wr(8'h0C, 32'h2);
    core(1'b0, 1'b0, 1'b1, 1'b0, 21'h0);
    chk(32'(fetch_addr), 32'h18);
    rd(8'h14);
    chk(rd_v, 32'h8);
    wr(8'h0C, 32'h0);
    core(1'b0, 1'b0, 1'b1, 1'b1, 21'h0);
    chk(32'(fetch_addr), 32'h18);
  endtask
  // Calls push the next word; pointer 30 to 31 sets full, write 1 clears
  task automatic sc_call();
    load_push <= 1'b1;
    core(1'b0, 1'b1, 1'b0, 1'b0, 21'h00200);
    load_push <= 1'b0;
    chk(32'(fetch_addr), 32'h200);
    rd(8'h10);
    chk(rd_v, 32'h3);
    rd(8'h14);
    chk(rd_v, 32'h1A);
    wr(8'h10, 32'h1E);
    load_push <= 1'b1;
    core(1'b0, 1'b1, 1'b0, 1'b0, 21'h00300);
    load_push <= 1'b0;
    rd(8'h10);
    chk(rd_v, 32'h9F);
    rd(8'h14);
    chk(rd_v, 32'h202);
    wr(8'h10, 32'h80);
    rd(8'h10);
    chk(rd_v, 32'h0);
  endtask
  // Last implemented word answers, first word above reads zero
  task automatic sc_top();
    core(1'b0, 1'b1, 1'b0, 1'b0, 21'h0FFFF);
    @(posedge clk);
    chk(32'(fetch_instr_q), 32'(16'h7FFF ^ 16'hA5C3));
    core(1'b0, 1'b1, 1'b0, 1'b0, 21'h10000);
    @(posedge clk);
    chk(32'(fetch_instr_q), 32'h0);
  endtask
  initial begin
    rst = 1'b1;
    {step_en, load_en, load_push, wake_irq, wake_high} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    load_target = 21'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    sc_reset();
    sc_latch();
    sc_step();
    sc_wake();
    sc_call();
    sc_top();
    test_done();
  end
endmodule
`default_nettype wire
